// ### hdl/uie_cfg.svh
// register map, field positions, reset values and timing counts of the usb interrupt enable block
`ifndef UIE_CFG_SVH
`define UIE_CFG_SVH

`define UIE_ADDR_W 16
`define UIE_IDX_ENABLE 12'hf36
`define UIE_IDX_STATUS 12'hf62

`define UIE_BIT_BUSRST 0
`define UIE_BIT_ERROR 1
`define UIE_BIT_ACTV 2
`define UIE_BIT_TRN 3
`define UIE_BIT_IDLE 4
`define UIE_BIT_STALL 5
`define UIE_BIT_SOF 6
`define UIE_BIT_UNUSED 7

`define UIE_ENABLE_RESET 8'h00
`define UIE_STATUS_RESET 8'h00
`define UIE_ENABLE_WMASK 8'h7f
`define UIE_STATUS_SW_MASK 8'h7d

`define UIE_CLK_MHZ 25
`define UIE_IDLE_TIME_US 3000
`define UIE_IDLE_CYCLES (`UIE_IDLE_TIME_US * `UIE_CLK_MHZ)

`endif

// ### hdl/uie_pkg.sv
// shared types of the usb interrupt enable block
package uie_pkg;
  typedef logic [7:0] uie_byte_t;
  typedef enum logic [1:0] {
    UIE_RESP_OKAY = 2'b00,
    UIE_RESP_SLVERR = 2'b10
  } uie_resp_e;
endpackage : uie_pkg

// ### hdl/uie_idle_if.sv
// idle detect link between the top and its idle timer
`timescale 1ns/1ns
interface uie_idle_if;
  logic bus_idle;
  logic idle_evt;
  modport timer (input bus_idle, output idle_evt);
  modport owner (output bus_idle, input idle_evt);
endinterface : uie_idle_if

// ### hdl/uie_idle_timer.sv
// idle detector: pulses once after the bus stays idle long enough
`timescale 1ns/1ns
`include "uie_cfg.svh"
module uie_idle_timer #(
  parameter int unsigned IDLE_CYCLES = `UIE_IDLE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  uie_idle_if.timer idle
);
  localparam logic [16:0] LAST = 17'(IDLE_CYCLES);

  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  logic evt_r;
  logic evt_nxt;

  // saturating count so one unbroken idle stretch yields a single pulse
  assign cnt_nxt = !idle.bus_idle ? 17'h00000 : (cnt_r == LAST) ? cnt_r : cnt_r + 17'h00001;
  assign evt_nxt = idle.bus_idle && (cnt_r == LAST - 17'h00001);
  assign idle.idle_evt = evt_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt_r <= 17'h00000;
      evt_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      evt_r <= evt_nxt;
    end
  end

  idle_time_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    evt_r |-> cnt_r == LAST && $past(idle.bus_idle))
    else $error("idle pulse without full idle stretch");

  idle_break_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !idle.bus_idle |=> !evt_r && cnt_r == 17'h00000)
    else $error("idle count not restarted by bus activity");

  idle_seen_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) evt_r);
endmodule : uie_idle_timer

// ### hdl/uie_top.sv
// usb status flags, per-source interrupt enable mask and axi4-lite register slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "uie_cfg.svh"

// Functional notes
// - set enable bit forwards its status flag
// - enables gate only interrupt forwarding
// - flags still set while enable clear
// - bit 6 enables start-of-frame interrupt
// - bit 5 enables stall sent interrupt
// - bit 4 enables idle detect interrupt
// - bit 3 enables transaction done interrupt
// - bit 2 enables bus activity interrupt
// - bit 1 enables combined error interrupt
// - bit 0 enables bus reset interrupt
// - bit 7 ignores writes, reads zero
// - enabled flags ored into one request
// - flags except error sticky until written zero; one sets
// - idle flag after 3 ms idle
module uie_top import uie_pkg::*; #(
  parameter int unsigned IDLE_CYCLES = `UIE_IDLE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [`UIE_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [`UIE_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_sof_evt,
  input wire logic i_stall_evt,
  input wire logic i_trn_evt,
  input wire logic i_actv_evt,
  input wire logic i_busrst_evt,
  input wire logic i_err_any,
  input wire logic i_bus_idle,
  output logic o_combined_usb_irq
);

  // registers are word indices; byte address is four times the index
  function automatic logic uie_hit(input logic [`UIE_ADDR_W-1:0] addr, input logic [11:0] idx);
    uie_hit = (addr[`UIE_ADDR_W-1:2] == {2'b00, idx});
  endfunction : uie_hit

  uie_idle_if idle_link ();

  uie_idle_timer #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_idle (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .idle(idle_link.timer)
  );

  assign idle_link.bus_idle = i_bus_idle;

  // register state
  uie_byte_t usb_interrupt_enable_r;
  uie_byte_t usb_interrupt_enable_nxt;
  uie_byte_t usb_interrupt_status_r;
  uie_byte_t usb_interrupt_status_nxt;
  logic irq_r;
  logic irq_nxt;

  // write channel state
  logic aw_held_r;
  logic aw_held_nxt;
  logic [`UIE_ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic w_held_nxt;
  logic [7:0] w_data_r;
  logic w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic bvalid_nxt;
  uie_resp_e bresp_r;

  // read channel state
  logic arready_r;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  uie_resp_e rresp_r;

  // write decode
  wire aw_take = i_awvalid && awready_r;
  wire w_take = i_wvalid && wready_r;
  wire wr_do = aw_held_r && w_held_r && !bvalid_r;
  wire wr_hit_en = uie_hit(aw_addr_r, `UIE_IDX_ENABLE);
  wire wr_hit_st = uie_hit(aw_addr_r, `UIE_IDX_STATUS);
  wire wr_mapped = wr_hit_en || wr_hit_st;
  wire wr_en = wr_do && wr_hit_en && w_strb_r;
  wire wr_st = wr_do && wr_hit_st && w_strb_r;

  assign aw_held_nxt = aw_held_r ? !wr_do : aw_take;
  assign w_held_nxt = w_held_r ? !wr_do : w_take;
  // a new write waits until the previous answer is taken
  assign bvalid_nxt = wr_do || (bvalid_r && !i_bready);

  // read decode
  wire ar_take = i_arvalid && arready_r;
  wire rd_hit_en = uie_hit(i_araddr, `UIE_IDX_ENABLE);
  wire rd_hit_st = uie_hit(i_araddr, `UIE_IDX_STATUS);
  // unmapped reads answer zero with an error response
  wire [31:0] rd_val = rd_hit_en ? {24'h000000, usb_interrupt_enable_r} :
                       rd_hit_st ? {24'h000000, usb_interrupt_status_r} : 32'h00000000;
  wire uie_resp_e rd_resp = (rd_hit_en || rd_hit_st) ? UIE_RESP_OKAY : UIE_RESP_SLVERR;

  assign rvalid_nxt = ar_take || (rvalid_r && !i_rready);

  // hardware events set flags regardless of the enable mask
  wire uie_byte_t hw_set = {1'b0, i_sof_evt, i_stall_evt, idle_link.idle_evt,
                            i_trn_evt, i_actv_evt, 1'b0, i_busrst_evt};
  wire uie_byte_t sw_keep = wr_st ? (w_data_r & `UIE_STATUS_SW_MASK)
                                  : (usb_interrupt_status_r & `UIE_STATUS_SW_MASK);
  // error flag mirrors the external error summary and is not software writable
  wire uie_byte_t err_level = {6'h00, i_err_any, 1'b0};

  assign usb_interrupt_status_nxt = hw_set | sw_keep | err_level;
  // top bit is never stored so it reads back zero
  assign usb_interrupt_enable_nxt = wr_en ? (w_data_r & `UIE_ENABLE_WMASK)
                                          : usb_interrupt_enable_r;
  // one combined request; computed from next values so it tracks the flags without lag
  assign irq_nxt = |(usb_interrupt_status_nxt & usb_interrupt_enable_nxt);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      usb_interrupt_enable_r <= `UIE_ENABLE_RESET;
      usb_interrupt_status_r <= `UIE_STATUS_RESET;
      irq_r <= 1'b0;
    end else begin
      usb_interrupt_enable_r <= usb_interrupt_enable_nxt;
      usb_interrupt_status_r <= usb_interrupt_status_nxt;
      irq_r <= irq_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awready_r <= !aw_held_nxt;
      wready_r <= !w_held_nxt;
      bvalid_r <= bvalid_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      aw_addr_r <= {`UIE_ADDR_W{1'b0}};
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
      bresp_r <= UIE_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_r <= i_awaddr;
      end
      // only the low byte lane carries register bits
      if (w_take) begin
        w_data_r <= i_wdata[7:0];
        w_strb_r <= i_wstrb[0];
      end
      if (wr_do) begin
        bresp_r <= wr_mapped ? UIE_RESP_OKAY : UIE_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= UIE_RESP_OKAY;
    end else begin
      // one read in flight; the address channel reopens once the answer is taken
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_val;
        rresp_r <= rd_resp;
      end
    end
  end

  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_combined_usb_irq = irq_r;

  // helper: an enable read is answered on the next cycle
  // the answer shows the mask as it stood when the address was taken
  logic rd_en_pend_r;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rd_en_pend_r <= 1'b0;
    end else if (ar_take) begin
      rd_en_pend_r <= rd_hit_en;
    end
  end

  irq_or_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_combined_usb_irq == |(usb_interrupt_status_r & usb_interrupt_enable_r))
    else $error("combined request differs from enabled flags");

  irq_masked_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (usb_interrupt_enable_r == 8'h00) |-> !o_combined_usb_irq)
    else $error("request raised with every enable clear");

  poll_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_sof_evt |=> usb_interrupt_status_r[`UIE_BIT_SOF])
    else $error("start-of-frame flag not set by its event");

  flag_sticky_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    usb_interrupt_status_r[`UIE_BIT_STALL] && !wr_st |=> usb_interrupt_status_r[`UIE_BIT_STALL])
    else $error("stall flag dropped without a software write");

  flag_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wr_st && !w_data_r[`UIE_BIT_TRN] && !i_trn_evt |=> !usb_interrupt_status_r[`UIE_BIT_TRN])
    else $error("transaction flag not cleared by writing zero");

  enable_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wr_en |=> usb_interrupt_enable_r == ($past(w_data_r) & 8'h7f))
    else $error("enable register did not take the written byte");

  top_bit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(o_rvalid) && rd_en_pend_r |-> o_rdata[7:0] == $past(usb_interrupt_enable_r) && !o_rdata[7])
    else $error("enable read shows bit seven or wrong value");

  reset_clear_a: assert property (@(posedge i_clock)
    $rose(i_rst_n) |-> usb_interrupt_enable_r == 8'h00 && !o_combined_usb_irq)
    else $error("enable bits not cleared by reset");

  write_answer_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wr_do |=> o_bvalid && o_awready && o_wready)
    else $error("write response missing one cycle after write");

  read_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read answer changed before it was taken");

  // register bus answers, refused accesses, the unused top bit and the flag sources
  read_answer_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ar_take |=> o_rvalid && !o_arready)
    else $error("read answer missing one cycle after address");

  read_block_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_rvalid |-> !o_arready)
    else $error("second read address accepted while answer pending");

  write_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write answer changed before it was taken");

  read_upper_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_rvalid |-> o_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  read_miss_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_rvalid && o_rresp == UIE_RESP_SLVERR |-> o_rdata == 32'h00000000)
    else $error("unmapped read returned data");

  refused_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wr_do && !wr_en |=> $stable(usb_interrupt_enable_r))
    else $error("enable changed by a refused write");

  unused_bit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !usb_interrupt_enable_r[`UIE_BIT_UNUSED] && !usb_interrupt_status_r[`UIE_BIT_UNUSED])
    else $error("unimplemented top bit was stored");

  event_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rst_n && |hw_set |=> (usb_interrupt_status_r & $past(hw_set)) == $past(hw_set))
    else $error("hardware event did not set its flag");

  err_mirror_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rst_n |=> usb_interrupt_status_r[`UIE_BIT_ERROR] == $past(i_err_any))
    else $error("error flag does not follow its source");

  irq_rise_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(o_combined_usb_irq));
  sw_set_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) wr_st && w_data_r[`UIE_BIT_SOF]);
  masked_poll_c: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    usb_interrupt_status_r[`UIE_BIT_IDLE] && !usb_interrupt_enable_r[`UIE_BIT_IDLE]);
  bad_addr_c: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    o_bvalid && o_bresp == UIE_RESP_SLVERR);

endmodule : uie_top

// ### tb/uie_usb_engine.sv
// far-side model: the usb engine raising status conditions for the block
`timescale 1ns/1ns
module uie_usb_engine (
  input wire logic i_clock,
  input wire logic [6:0] i_cause,
  output logic [6:0] o_evt
);
  // registered like a real engine, so conditions land one clock after the bench asks
  always_ff @(posedge i_clock) begin
    o_evt <= i_cause;
  end
endmodule : uie_usb_engine

// ### tb/test_usb_interrupt_enable_mask.sv
// self-checking testbench for the usb interrupt enable block
`timescale 1ns/1ns
`include "uie_cfg.svh"
module test_usb_interrupt_enable_mask;
  localparam int IDLE = 20;
  localparam logic [15:0] EN = 16'(`UIE_IDX_ENABLE * 4);
  localparam logic [15:0] ST = 16'(`UIE_IDX_STATUS * 4);
  localparam logic [1:0] OK = uie_pkg::UIE_RESP_OKAY;
  localparam logic [1:0] SLV = uie_pkg::UIE_RESP_SLVERR;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  logic [6:0] cause, evt;
  int fails, checks_done;

  uie_top #(.IDLE_CYCLES(IDLE)) dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_sof_evt(evt[6]),
    .i_stall_evt(evt[5]), .i_trn_evt(evt[3]), .i_actv_evt(evt[2]), .i_busrst_evt(evt[0]),
    .i_err_any(evt[1]), .i_bus_idle(evt[4]), .o_combined_usb_irq(irq)
  );
  uie_usb_engine engine (.i_clock(clock), .i_cause(cause), .o_evt(evt));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [1:0] er, input logic [31:0] exp);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
    chk(rdata, exp);
  endtask : rd

  // error and idle are levels and stay up; idle must outlast the detector count
  task automatic fire(input int b);
    @(posedge clock);
    cause[b] <= 1'b1;
    repeat (b == 4 ? IDLE + 6 : 1) @(posedge clock);
    if (b != 1 && b != 4) cause[b] <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : fire

  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, cause} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rd(EN, OK, 32'h0);
    rd(ST, OK, 32'h0);
    wr(EN, 8'hff, OK);
    rd(EN, OK, 32'h7f);
    // a write with its low strobe clear must leave the mask alone
    wstrb <= 4'h0;
    wr(EN, 8'h00, OK);
    wstrb <= 4'hf;
    rd(EN, OK, 32'h7f);
    for (int b = 0; b < 7; b++) begin
      wr(EN, 8'h00, OK);
      fire(b);
      rd(ST, OK, 32'h1 << b);
      chk({31'h0, irq}, 32'h0);
      wr(EN, 8'h7f ^ (8'h1 << b), OK);
      chk({31'h0, irq}, 32'h0);
      wr(EN, 8'h1 << b, OK);
      chk({31'h0, irq}, 32'h1);
      if (b == 1) begin
        cause <= 7'h0;
        repeat (3) @(posedge clock);
      end else wr(ST, 8'h00, OK);
      rd(ST, OK, 32'h0);
      chk({31'h0, irq}, 32'h0);
      cause <= 7'h0;
    end
    wr(EN, 8'h7f, OK);
    wr(ST, 8'hff, OK);
    rd(ST, OK, 32'h7d);
    chk({31'h0, irq}, 32'h1);
    wr(ST, 8'h00, OK);
    chk({31'h0, irq}, 32'h0);
    wr(16'h0010, 8'h55, SLV);
    rd(16'h0010, SLV, 32'h0);
    rd(EN, OK, 32'h7f);
    wr(ST, 8'h40, OK);
    chk({31'h0, irq}, 32'h1);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(EN, OK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    results();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    results();
  end
endmodule : test_usb_interrupt_enable_mask
